/* core/crafc_top.sv */
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps
// What this block does
// - pre-preamble AFC wait is (field+1) times two bits
// - short wait zero disables AFC before preamble
// - antenna switching wait counts data bits
// - noise immunity bit active in direct mode
// - before preamble gain shifts by fast gear
// - preamble detect shifts gain by slow gear
// - oversampling ratio has three fraction bits
// - nco offset is twenty bits over three registers
// - reset values give forty kbps, no Manchester
// - loop gain eleven bits, top three separate
// - bypass skips divide by three; exponent sets decimation
module crafc_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic preamble_det, // pulse from the preamble detector
   input wire logic rx_restart, // pulse when receive starts again
   input wire logic afc_corr_done, // pulse after each AFC correction
   input wire logic bit_tick, // pulse once per data bit
   input wire logic ant_switch, // pulse when the antenna is switched
   input wire logic direct_mode, // level, receiver in direct mode
   input wire logic div3_stage_bypass, // level, skip divide by three
   input wire logic [2:0] decim_exp, // decimation exponent
   output logic afc_update_en, // AFC may correct now
   output logic ant_wait_busy, // antenna switching wait running
   output logic noise_immunity_en, // immunity aid to the demodulator
   output logic slow_gear, // slow gear in use
   output logic [10:0] bcr_loop_gain, // effective recovery gain
   output logic [10:0] osr_ratio, // oversampling ratio, 3 frac bits
   output logic [19:0] nco_offset, // nco offset word
   output logic stall_ctrl, // recovery stall control
   output logic [9:0] decim_factor // total decimation of the IF path
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] afc_timing; // short wait and antenna wait
      logic [7:0] gearshift; // immunity bit and both gears
      logic [7:0] osr_lo; // ratio bits 7:0
      logic [7:0] offset_hi; // ratio 10:8, stall, nco 19:16
      logic [7:0] offset_mid; // nco 15:8
      logic [7:0] offset_lo; // nco 7:0
      logic [7:0] gain_hi; // gain 10:8 plus reserved
      logic [7:0] gain_lo; // gain 7:0
      logic dp_write; // data phase of a write pending
      logic [7:0] dp_idx; // register index of that write
      logic [7:0] rdata; // read data for the data phase
      logic slow; // preamble seen in this receive
      logic noise_imm; // registered immunity enable
      logic [9:0] decim; // registered decimation factor
   } crafc_top_t;

   crafc_top_t st_ff;
   crafc_top_t nxt_st;

   logic addr_ok; // address phase taken this cycle
   logic [7:0] a_idx; // index from the address bus
   logic sw_busy; // short wait running
   logic [2:0] sh_field; // short wait field
   logic [2:0] an_field; // antenna wait field
   logic [crafc_pkg::WAIT_W-1:0] sw_load; // bits of short wait
   logic sw_start; // begin a short wait
   logic [10:0] gain_val; // programmed loop gain

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   assign addr_ok = hsel && hready && (htrans == crafc_pkg::HTRANS_NONSEQ);
   assign a_idx = haddr[9:2];
   assign sh_field = st_ff.afc_timing[crafc_pkg::SHWAIT_LSB +: 3];
   assign an_field = st_ff.afc_timing[crafc_pkg::ANWAIT_LSB +: 3];
   assign gain_val = {st_ff.gain_hi[crafc_pkg::GAIN_HI_MSB:0], st_ff.gain_lo};

   // short wait length: (field + 1) * 2 bit periods
   assign sw_load = {1'b0, sh_field, 1'b0} + 5'h02;
   // only corrections before the preamble start the wait, none if zero
   assign sw_start = afc_corr_done && !st_ff.slow && (sh_field != 3'h0);

   // next state of registers, bus and preamble phase
   always_comb begin
      nxt_st = st_ff;
      // write data phase: store the byte lane 0 into the chosen register
      if (st_ff.dp_write) begin
         unique case (st_ff.dp_idx)
            crafc_pkg::IDX_AFC_TIMING: begin
               nxt_st.afc_timing = {2'h0, hwdata[crafc_pkg::AFC_TIMING_MSB:0]};
            end
            crafc_pkg::IDX_GEARSHIFT: begin
               nxt_st.gearshift = hwdata[7:0];
            end
            crafc_pkg::IDX_OSR_LO: begin
               nxt_st.osr_lo = hwdata[7:0];
            end
            crafc_pkg::IDX_OFFSET_HI: begin
               nxt_st.offset_hi = hwdata[7:0];
            end
            crafc_pkg::IDX_OFFSET_MID: begin
               nxt_st.offset_mid = hwdata[7:0];
            end
            crafc_pkg::IDX_OFFSET_LO: begin
               nxt_st.offset_lo = hwdata[7:0];
            end
            crafc_pkg::IDX_GAIN_HI: begin
               nxt_st.gain_hi = hwdata[7:0];
            end
            crafc_pkg::IDX_GAIN_LO: begin
               nxt_st.gain_lo = hwdata[7:0];
            end
            default: begin
               // unmapped writes are dropped
            end
         endcase
      end
      // address phase: note writes, fetch reads from the updated copy
      nxt_st.dp_write = addr_ok && hwrite;
      nxt_st.dp_idx = a_idx;
      nxt_st.rdata = 8'h00;
      if (addr_ok && !hwrite) begin
         unique case (a_idx)
            crafc_pkg::IDX_AFC_TIMING: begin
               nxt_st.rdata = nxt_st.afc_timing;
            end
            crafc_pkg::IDX_GEARSHIFT: begin
               nxt_st.rdata = nxt_st.gearshift;
            end
            crafc_pkg::IDX_OSR_LO: begin
               nxt_st.rdata = nxt_st.osr_lo;
            end
            crafc_pkg::IDX_OFFSET_HI: begin
               nxt_st.rdata = nxt_st.offset_hi;
            end
            crafc_pkg::IDX_OFFSET_MID: begin
               nxt_st.rdata = nxt_st.offset_mid;
            end
            crafc_pkg::IDX_OFFSET_LO: begin
               nxt_st.rdata = nxt_st.offset_lo;
            end
            crafc_pkg::IDX_GAIN_HI: begin
               nxt_st.rdata = nxt_st.gain_hi;
            end
            crafc_pkg::IDX_GAIN_LO: begin
               nxt_st.rdata = nxt_st.gain_lo;
            end
            default: begin
               nxt_st.rdata = 8'h00;
            end
         endcase
      end
      // preamble phase: detection wins over a restart in the same cycle
      if (preamble_det) begin
         nxt_st.slow = 1'b1;
      end else if (rx_restart) begin
         nxt_st.slow = 1'b0;
      end
      // immunity aid only has effect in direct mode
      nxt_st.noise_imm = st_ff.gearshift[crafc_pkg::NOISE_IMM_BIT] && direct_mode;
      // IF decimation: 3 * 2^exp, or 2^exp when the stage is bypassed
      if (div3_stage_bypass) begin
         nxt_st.decim = 10'h001 << decim_exp;
      end else begin
         nxt_st.decim = 10'h003 << decim_exp;
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff.afc_timing <= crafc_pkg::RST_AFC_TIMING;
         st_ff.gearshift <= crafc_pkg::RST_GEARSHIFT;
         st_ff.osr_lo <= crafc_pkg::RST_OSR_LO;
         st_ff.offset_hi <= crafc_pkg::RST_OFFSET_HI;
         st_ff.offset_mid <= crafc_pkg::RST_OFFSET_MID;
         st_ff.offset_lo <= crafc_pkg::RST_OFFSET_LO;
         st_ff.gain_hi <= crafc_pkg::RST_GAIN_HI;
         st_ff.gain_lo <= crafc_pkg::RST_GAIN_LO;
         st_ff.dp_write <= 1'b0;
         st_ff.dp_idx <= 8'h00;
         st_ff.rdata <= 8'h00;
         st_ff.slow <= 1'b0;
         st_ff.noise_imm <= 1'b0;
         st_ff.decim <= 10'h003;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ---------------------------------------------------------------
   // waits counted in data bits
   // ---------------------------------------------------------------

   // hold-off after each pre-preamble AFC correction
   crafc_bit_timer #(
      .W(crafc_pkg::WAIT_W)
   ) u_short_wait (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(sw_start),
      .load(sw_load),
      .bit_tick(bit_tick),
      .busy(sw_busy)
   );

   // antenna switching settle time
   crafc_bit_timer #(
      .W(crafc_pkg::WAIT_W)
   ) u_ant_wait (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(ant_switch),
      .load({2'b00, an_field}),
      .bit_tick(bit_tick),
      .busy(ant_wait_busy)
   );

   // ---------------------------------------------------------------
   // loop gain gearing
   // ---------------------------------------------------------------
   crafc_gear_shift #(
      .GW(crafc_pkg::GAIN_W)
   ) u_gear (
      .hclk(hclk),
      .hresetn(hresetn),
      .gain(gain_val),
      .fast_gear(st_ff.gearshift[crafc_pkg::CRFAST_LSB +: 3]),
      .slow_gear(st_ff.gearshift[crafc_pkg::CRSLOW_LSB +: 3]),
      .use_slow(st_ff.slow),
      .loop_gain(bcr_loop_gain)
   );

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------

   // after the preamble the wait no longer gates AFC
   assign afc_update_en = st_ff.slow || ((sh_field != 3'h0) && !sw_busy);
   assign noise_immunity_en = st_ff.noise_imm;
   assign slow_gear = st_ff.slow;
   // ratio is fixed point, low bits are fraction
   assign osr_ratio = {st_ff.offset_hi[crafc_pkg::OSR_HI_LSB +: 3], st_ff.osr_lo};
   assign nco_offset = {st_ff.offset_hi[crafc_pkg::NCO_HI_LSB +: 4], st_ff.offset_mid,
                        st_ff.offset_lo};
   assign stall_ctrl = st_ff.offset_hi[crafc_pkg::STALL_BIT];
   assign decim_factor = st_ff.decim;

   // bus answer: always ready, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = {24'h000000, st_ff.rdata};

endmodule

/* core/crafc_pkg.sv */
package crafc_pkg;

   // ---------------------------------------------------------------
   // register indices (byte address = index * 4)
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_AFC_TIMING = 8'h1e;
   localparam logic [7:0] IDX_GEARSHIFT = 8'h1f;
   localparam logic [7:0] IDX_OSR_LO = 8'h20;
   localparam logic [7:0] IDX_OFFSET_HI = 8'h21;
   localparam logic [7:0] IDX_OFFSET_MID = 8'h22;
   localparam logic [7:0] IDX_OFFSET_LO = 8'h23;
   localparam logic [7:0] IDX_GAIN_HI = 8'h24;
   localparam logic [7:0] IDX_GAIN_LO = 8'h25;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_AFC_TIMING = 8'h0a;
   localparam logic [7:0] RST_GEARSHIFT = 8'h03;
   localparam logic [7:0] RST_OSR_LO = 8'h64;
   localparam logic [7:0] RST_OFFSET_HI = 8'h01;
   localparam logic [7:0] RST_OFFSET_MID = 8'h47;
   localparam logic [7:0] RST_OFFSET_LO = 8'hae;
   localparam logic [7:0] RST_GAIN_HI = 8'h02;
   localparam logic [7:0] RST_GAIN_LO = 8'h00;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int SHWAIT_LSB = 3; // short wait, 3 bits
   localparam int ANWAIT_LSB = 0; // antenna wait, 3 bits
   localparam int AFC_TIMING_MSB = 5; // bits 7:6 read zero
   localparam int NOISE_IMM_BIT = 6;
   localparam int CRFAST_LSB = 3;
   localparam int CRSLOW_LSB = 0;
   localparam int OSR_HI_LSB = 5; // osr bits 10:8
   localparam int STALL_BIT = 4;
   localparam int NCO_HI_LSB = 0; // nco bits 19:16, 4 bits
   localparam int GAIN_HI_MSB = 2; // gain bits 10:8
   localparam int OSR_FRAC_BITS = 3; // fixed point fraction of the ratio

   // ---------------------------------------------------------------
   // widths and counts
   // ---------------------------------------------------------------
   localparam int OSR_W = 11;
   localparam int NCO_W = 20;
   localparam int GAIN_W = 11;
   localparam int WAIT_W = 5; // (7 + 1) * 2 = 16 bits fits
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

endpackage

/* core/crafc_bit_timer.sv */
`timescale 1ns/10ps
// counts a number of data bits down on the bit tick
module crafc_bit_timer #(
   parameter int W = 5
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start, // load a new count
   input wire logic [W-1:0] load, // bits to wait, zero means none
   input wire logic bit_tick, // one pulse per data bit
   output logic busy // high while bits remain
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [W-1:0] cnt; // bits still to wait
   } crafc_tmr_t;

   crafc_tmr_t st_ff;
   crafc_tmr_t nxt_st;

   // next state: a fresh start overrides a running count
   always_comb begin
      nxt_st = st_ff;
      if (start) begin
         nxt_st.cnt = load;
      end else if (bit_tick && st_ff.cnt != '0) begin
         nxt_st.cnt = st_ff.cnt - 1'b1;
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign busy = (st_ff.cnt != '0);

endmodule

/* core/crafc_gear_shift.sv */
`timescale 1ns/10ps
// divides the loop gain by two to the selected gear
module crafc_gear_shift #(
   parameter int GW = 11
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [GW-1:0] gain, // programmed gain value
   input wire logic [2:0] fast_gear, // exponent before preamble
   input wire logic [2:0] slow_gear, // exponent after preamble
   input wire logic use_slow, // preamble seen
   output logic [GW-1:0] loop_gain // gain in use, registered
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [GW-1:0] gain; // effective loop gain
   } crafc_gear_t;

   crafc_gear_t st_ff;
   crafc_gear_t nxt_st;

   // next state: shift by the gear that matches the phase
   always_comb begin
      nxt_st = st_ff;
      if (use_slow) begin
         nxt_st.gain = gain >> slow_gear;
      end else begin
         nxt_st.gain = gain >> fast_gear;
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign loop_gain = st_ff.gain;

endmodule

/* verif/crafc_properties.sv */
`timescale 1ns/10ps
// watches gears, wait timers and decimation at the block's ports
module crafc_properties (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic preamble_det,
   input wire logic rx_restart,
   input wire logic afc_corr_done,
   input wire logic bit_tick,
   input wire logic ant_switch,
   input wire logic direct_mode,
   input wire logic div3_stage_bypass,
   input wire logic [2:0] decim_exp,
   input wire logic afc_update_en,
   input wire logic ant_wait_busy,
   input wire logic noise_immunity_en,
   input wire logic slow_gear,
   input wire logic [9:0] decim_factor
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ------------------------------------------
   // gear selection
   // ------------------------------------------
   a_slow_on_pre: assert property (preamble_det |=> slow_gear)
      else $error("slow gear missing after preamble");
   a_fast_on_restart: assert property (rx_restart && !preamble_det |=> !slow_gear)
      else $error("fast gear missing after restart");
   a_slow_holds: assert property (slow_gear && !rx_restart |=> slow_gear)
      else $error("slow gear dropped without restart");
   // ------------------------------------------
   // afc and antenna waits
   // ------------------------------------------
   a_wait_starts: assert property (afc_corr_done && !slow_gear |=> !afc_update_en || slow_gear)
      else $error("afc not held after correction");
   a_afc_after_pre: assert property (slow_gear |-> afc_update_en)
      else $error("afc held while in slow gear");
   a_ant_rise: assert property ($rose(ant_wait_busy) |-> $past(ant_switch))
      else $error("antenna wait started without switch");
   a_ant_end: assert property ($fell(ant_wait_busy) |-> $past(bit_tick) || $past(ant_switch))
      else $error("antenna wait ended off a bit tick");
   // ------------------------------------------
   // immunity and decimation
   // ------------------------------------------
   a_imm_direct: assert property (noise_immunity_en |-> $past(direct_mode))
      else $error("immunity aid outside direct mode");
   a_decim_rate: assert property ($past(hresetn) |-> decim_factor ==
      (($past(div3_stage_bypass) ? 10'h001 : 10'h003) << $past(decim_exp)))
      else $error("decimation factor wrong");
   c_pre: cover property (preamble_det);
   c_afc_wait: cover property ($fell(afc_update_en));
   c_ant_done: cover property ($fell(ant_wait_busy));
endmodule

bind crafc_top crafc_properties crafc_properties_i (.hclk(hclk), .hresetn(hresetn),
   .preamble_det(preamble_det), .rx_restart(rx_restart), .afc_corr_done(afc_corr_done),
   .bit_tick(bit_tick), .ant_switch(ant_switch), .direct_mode(direct_mode),
   .div3_stage_bypass(div3_stage_bypass), .decim_exp(decim_exp),
   .afc_update_en(afc_update_en), .ant_wait_busy(ant_wait_busy),
   .noise_immunity_en(noise_immunity_en), .slow_gear(slow_gear),
   .decim_factor(decim_factor));

/* verif/crafc_host.sv */
`timescale 1ns/10ps
// host software model: AHB-Lite master, single word transfers
module crafc_host (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   // bus idle at time zero
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
   end
   // address phase held until hready, then data phase held until hready
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= crafc_pkg::HTRANS_NONSEQ;
      haddr <= {22'h0, idx, 2'b00};
      hwrite <= wr;
      hwdata <= ~hwdata;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata[7:0];
   endtask
endmodule

/* verif/test_clock_recovery_afc_timing_config.sv */
`timescale 1ns/10ps
module test_clock_recovery_afc_timing_config;
   logic hclk = 1'b0;
   logic hresetn; // driven low at time zero so the async reset sees an edge
   logic hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic preamble_det = 1'b0, rx_restart = 1'b0, afc_corr_done = 1'b0;
   logic bit_tick = 1'b0, ant_switch = 1'b0, direct_mode = 1'b0;
   logic div3_stage_bypass = 1'b0;
   logic [2:0] decim_exp = 3'h0;
   logic afc_update_en, ant_wait_busy, noise_immunity_en, slow_gear, stall_ctrl;
   logic [10:0] bcr_loop_gain, osr_ratio;
   logic [19:0] nco_offset;
   logic [9:0] decim_factor;
   int errors = 0;
   int total_checks = 0;
   // register reset values and written values, from 0x1e upward
   // reset ratio 0x64 is the rounded ratio for 40 kbps
   localparam logic [7:0] RV [8] = '{8'h0a, 8'h03, 8'h64, 8'h01, 8'h47, 8'hae, 8'h02, 8'h00};
   // written ratio 0x578 stays above eight cycles per bit
   localparam logic [7:0] WV [8] = '{8'hff, 8'h05, 8'h78, 8'hb5, 8'h12, 8'h34, 8'hfd, 8'h40};

   always #20 hclk = ~hclk;

   crafc_host crafc_host_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   crafc_top crafc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .preamble_det(preamble_det),
      .rx_restart(rx_restart), .afc_corr_done(afc_corr_done), .bit_tick(bit_tick),
      .ant_switch(ant_switch), .direct_mode(direct_mode),
      .div3_stage_bypass(div3_stage_bypass), .decim_exp(decim_exp),
      .afc_update_en(afc_update_en), .ant_wait_busy(ant_wait_busy),
      .noise_immunity_en(noise_immunity_en), .slow_gear(slow_gear),
      .bcr_loop_gain(bcr_loop_gain), .osr_ratio(osr_ratio), .nco_offset(nco_offset),
      .stall_ctrl(stall_ctrl), .decim_factor(decim_factor));

   // -----------------------------
   // compares and drivers
   // -----------------------------
   task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chk_port(input string n, input logic [19:0] e, input logic [19:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] x;
      crafc_host_i.xfer(1'b1, idx, d, x);
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
      logic [7:0] x;
      crafc_host_i.xfer(1'b0, idx, 8'h00, x);
      chk_reg($sformatf("reg %h", idx), e, x);
   endtask
   // one-cycle pulses of preamble, restart, correction, antenna switch
   task automatic strobe(input logic [3:0] m);
      @(posedge hclk);
      {preamble_det, rx_restart, afc_corr_done, ant_switch} <= m;
      @(posedge hclk);
      {preamble_det, rx_restart, afc_corr_done, ant_switch} <= 4'h0;
      #1;
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge hclk);
         bit_tick <= 1'b1;
         @(posedge hclk);
         bit_tick <= 1'b0;
      end
      #1;
   endtask

   // -----------------------------
   // scenarios
   // -----------------------------
   task automatic t_reset;
      for (int i = 0; i < 8; i++) rdc(8'h1e + 8'(i), RV[i]);
      rdc(8'h26, 8'h00);
      chk_port("osr", 20'h064, 20'(osr_ratio));
      chk_port("nco", 20'h147ae, nco_offset);
      chk_port("gain", 20'h200, 20'(bcr_loop_gain));
      $display("t_reset done");
   endtask
   task automatic t_regs;
      for (int i = 0; i < 8; i++) begin
         wr(8'h1e + 8'(i), WV[i]);
         rdc(8'h1e + 8'(i), (i == 0) ? 8'h3f : WV[i]);
      end
      wr(8'h26, 8'h55);
      rdc(8'h26, 8'h00);
      chk_port("osr", 20'h578, 20'(osr_ratio));
      chk_port("nco", 20'h51234, nco_offset);
      chk_port("stall", 20'h1, 20'(stall_ctrl));
      chk_port("gain", 20'h540, 20'(bcr_loop_gain));
      $display("t_regs done");
   endtask
   task automatic t_gear;
      strobe(4'h8);
      chk_port("slow", 20'h1, 20'(slow_gear));
      @(posedge hclk);
      #1;
      chk_port("gain", 20'h02a, 20'(bcr_loop_gain));
      strobe(4'h4);
      chk_port("slow", 20'h0, 20'(slow_gear));
      @(posedge hclk);
      #1;
      chk_port("gain", 20'h540, 20'(bcr_loop_gain));
      strobe(4'hc);
      chk_port("slow", 20'h1, 20'(slow_gear));
      strobe(4'h4);
      $display("t_gear done");
   endtask
   task automatic t_afc;
      wr(8'h1e, 8'h0a);
      chk_port("afc", 20'h1, 20'(afc_update_en));
      strobe(4'h3);
      chk_port("afc", 20'h0, 20'(afc_update_en));
      chk_port("ant", 20'h1, 20'(ant_wait_busy));
      ticks(1);
      chk_port("ant", 20'h1, 20'(ant_wait_busy));
      ticks(1);
      chk_port("ant", 20'h0, 20'(ant_wait_busy));
      ticks(1);
      chk_port("afc", 20'h0, 20'(afc_update_en));
      ticks(1);
      chk_port("afc", 20'h1, 20'(afc_update_en));
      wr(8'h1e, 8'h02);
      strobe(4'h2);
      chk_port("afc", 20'h0, 20'(afc_update_en));
      strobe(4'h8);
      chk_port("afc", 20'h1, 20'(afc_update_en));
      strobe(4'h4);
      $display("t_afc done");
   endtask
   task automatic t_noise;
      wr(8'h1f, 8'h45);
      chk_port("imm", 20'h0, 20'(noise_immunity_en));
      @(posedge hclk);
      direct_mode <= 1'b1;
      @(posedge hclk);
      #1;
      chk_port("imm", 20'h1, 20'(noise_immunity_en));
      wr(8'h1f, 8'h05);
      // the immunity enable is registered one edge after the write lands
      @(posedge hclk);
      #1;
      chk_port("imm", 20'h0, 20'(noise_immunity_en));
      direct_mode <= 1'b0;
      $display("t_noise done");
   endtask
   task automatic t_decim;
      for (int b = 0; b < 2; b++) begin
         for (int e = 0; e < 8; e++) begin
            @(posedge hclk);
            div3_stage_bypass <= 1'(b);
            decim_exp <= 3'(e);
            repeat (2) @(posedge hclk);
            #1;
            chk_port("decim", ((b == 1) ? 20'h1 : 20'h3) << e, 20'(decim_factor));
         end
      end
      $display("t_decim done");
   endtask

   task automatic results;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // main sequence after reset
   initial begin
      hresetn = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_regs;
      t_gear;
      t_afc;
      t_noise;
      t_decim;
      results;
   end
   // watchdog for a hung handshake
   initial begin
      repeat (5000) @(posedge hclk);
      errors++;
      results;
   end
endmodule
